// >>> hdl/dlpc_link_phy_regs.sv
// Configuration and status registers of the single-wire debug link PHY.
`timescale 1ns/1ps
module dlpc_link_phy_regs
  import dlpc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h3, // Arbitrary revision code.
  parameter int TMO_CYC = DLPC_TMO_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire dlpc_req_t req,
  output logic [7:0] rdData,
  output logic accSel,
  input wire dlpc_err_t errIn,
  input wire logic accBusy,
  input wire logic accDone,
  input wire logic sysResetHit,
  input wire logic rspWanted,
  input wire logic nackWanted,
  input wire logic txStart,
  input wire logic txNextByte,
  output logic rspAllow,
  output logic nackAllow,
  output logic contentionOn,
  output logic [15:0] txWait,
  output logic linkDisable,
  output logic clkReq
);
  // How this block sits in the link.
  // The link instruction decoder is the only master of the request port.
  // It raises req.rd or req.wr for exactly one clock per register access.
  // There is no path from the processor side, so these registers stay
  // private to the debugger.
  // A read of offsets 0 to 3 is answered one clock later on rdData.
  // The read data then holds until the next read of that range.
  // Offsets 4 to C are not stored here.
  // They are flagged on accSel so that the access interface answers them.
  // Offsets above C select nothing and leave rdData unchanged.
  // The framing logic reports its errors as one-clock pulses on errIn.
  // A single error signature is kept, so only the most severe error of a
  // cycle is recorded.
  // A later error overwrites an earlier one that has not yet been read.
  // The debugger therefore sees the most recent problem, not the first.
  // The time-out watches the access layer busy and done handshake.
  // It counts only while an answer is owed.
  // Each fresh wait therefore starts from zero.
  // The transmit side asks for a wait count on txStart and on txNextByte.
  // txStart marks the turn from receive to transmit.
  // txNextByte marks each further byte of a multi-byte load.
  // The framer counts txWait down itself; this block only sets it.
  // The steering outputs are plain decodes of the control registers.
  // They are combinational on purpose, so that a new setting takes effect
  // on the very next frame without an extra clock of delay.
  // The disable bit stops the link and clears the phy control register; the disable control register keeps its value.
  // Clearing that bit again or a reset are the only ways back to a working link.
  // A limitation: the gap length assumes a twelve bit idle character.
  // A framer that uses another character length must scale txWait.
  // Another limitation: TMO_CYC below 2 would fire on the first wait cycle.
  // The elaboration check below refuses such values.

  // Refuse a time-out length that the 17 bit counter cannot serve.
  initial begin
    if (TMO_CYC < 2 || TMO_CYC > 65536) begin
      $error("TMO_CYC out of range");
    end
  end

  // Live register state.
  logic [7:0] phyCtrl;
  logic [7:0] disCtrl;
  logic [2:0] errSig;
  logic [16:0] tmoCnt;
  logic tmoHit;

  // Guard time cycles from the select field, zero when off.
  function automatic logic [15:0] guardCycles(input logic [2:0] sel);
    if (sel == DLPC_GT_OFF) begin
      return 16'h0000;
    end
    return 16'(DLPC_GT_MAX_CYC >> sel);
  endfunction : guardCycles

  // Decode; only offsets 0..3 are held here, 4..C go to the access layer.
  // The decode is kept combinational so that accSel is valid in the same
  // clock as the request, which lets the access interface answer in time.
  wire logic inPhy = req.addr <= DLPC_OFS_PHY_LAST;
  assign accSel = !inPhy && req.addr <= DLPC_OFS_ACC_LAST;
  wire logic rdErr = req.rd && req.addr == DLPC_OFS_ERR;
  wire logic wrPhy = req.wr && req.addr == DLPC_OFS_PHY;
  wire logic wrDis = req.wr && req.addr == DLPC_OFS_DIS;

  // Error priority: contention first, as it corrupts every other check.
  // A clock error comes next, since it makes the rest of the frame
  // meaningless; the time-out follows, then frame and parity errors.
  // Masked errors are dropped here and never reach the signature.
  wire logic parOk = !phyCtrl[DLPC_POS_PAR];
  wire logic contOk = !disCtrl[DLPC_POS_CONT];
  wire logic [2:0] newSig =
    (errIn.contention && contOk) ? DLPC_SIG_CONT :
    errIn.clock ? DLPC_SIG_CLK :
    tmoHit ? DLPC_SIG_TMO :
    errIn.frame ? DLPC_SIG_FRM :
    (errIn.parity && parOk) ? DLPC_SIG_PAR : DLPC_SIG_NONE;
  wire logic anyErr = newSig != DLPC_SIG_NONE;

  // Time-out counter runs while the access layer owes an answer.
  // The done pulse stops it in the same cycle, so an answer that arrives
  // on the last counted cycle is still taken as on time.
  wire logic tmoOn = !phyCtrl[DLPC_POS_TMO] && accBusy && !accDone;
  assign tmoHit = tmoOn && tmoCnt == 17'(TMO_CYC - 1);

  always_ff @(posedge clk) begin
    // Counter restarts with every new wait so an on-time answer is not blamed for an earlier wait.
    if (rst || linkDisable || !tmoOn || tmoHit) begin
      tmoCnt <= '0;
    end else begin
      tmoCnt <= tmoCnt + 17'h00001;
    end
  end

  // Configuration; the disable bit itself survives so it can be cleared.
  // Writes are masked so that unused bits always read back as zero.
  // Writes to the status offsets fall through and change nothing.
  always_ff @(posedge clk) begin
    if (rst) begin
      phyCtrl <= DLPC_PHY_RST;
      disCtrl <= DLPC_DIS_RST;
    end else if (linkDisable) begin
      phyCtrl <= DLPC_PHY_RST;
      disCtrl <= wrDis ? (req.data & DLPC_DIS_MASK) : disCtrl;
    end else begin
      if (wrPhy) begin
        phyCtrl <= req.data & DLPC_PHY_MASK;
      end
      if (wrDis) begin
        disCtrl <= req.data & DLPC_DIS_MASK;
      end
    end
  end

  // Signature: a new error wins over the clear-on-read of the same cycle.
  // Losing the error instead would hide a fault that the debugger has not
  // yet seen; the read still returns the older value it sampled.
  always_ff @(posedge clk) begin
    if (rst || linkDisable) begin
      errSig <= DLPC_SIG_RST;
    end else if (anyErr) begin
      errSig <= newSig;
    end else if (rdErr) begin
      errSig <= DLPC_SIG_NONE;
    end
  end

  // Read data registered one cycle after the request.
  // The register sits on the output so that the framer can shift it out
  // without a long combinational path from the request decode.
  wire logic [7:0] rdMux =
    (req.addr == DLPC_OFS_REV) ? {REVISION, 4'h0} :
    (req.addr == DLPC_OFS_ERR) ? {5'h00, errSig} :
    (req.addr == DLPC_OFS_PHY) ? phyCtrl :
    (req.addr == DLPC_OFS_DIS) ? disCtrl : 8'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (req.rd && inPhy) begin
      rdData <= rdMux;
    end
  end

  // Transmit pacing: guard before first byte, idle gap between bytes.
  // txStart wins over txNextByte, so the first byte of a response never
  // gets the idle gap, only the guard time.
  // The gap is a fixed length in link clock cycles.
  wire logic [15:0] gapCycles = 16'(DLPC_IDLE_CHARS * DLPC_CHAR_BITS);
  always_ff @(posedge clk) begin
    if (rst || linkDisable) begin
      txWait <= 16'h0000;
    end else if (txStart) begin
      txWait <= guardCycles(phyCtrl[2:0]);
    end else if (txNextByte) begin
      txWait <= phyCtrl[DLPC_POS_GAP] ? gapCycles : 16'h0000;
    end
  end

  // Outward steering of the framing logic.
  // While disabled the link answers nothing and detects nothing.
  assign linkDisable = disCtrl[DLPC_POS_DIS];
  assign clkReq = !disCtrl[DLPC_POS_DIS];
  assign rspAllow = rspWanted && !phyCtrl[DLPC_POS_RSP] &&
    !linkDisable;
  assign nackAllow = nackWanted && !linkDisable &&
    !(sysResetHit && disCtrl[DLPC_POS_NACK]);
  assign contentionOn = contOk && !linkDisable;

  // Checks on the behaviour above.
  sig_clear_a: assert property (@(posedge clk) disable iff (rst)
    rdErr && !anyErr && !linkDisable |=> errSig == 3'h0)
    else $error("signature not cleared by read");
  sig_load_a: assert property (@(posedge clk) disable iff (rst)
    anyErr && !linkDisable |=> errSig == $past(newSig))
    else $error("signature not loaded");
  sig_reserved_a: assert property (@(posedge clk) disable iff (rst)
    errSig != 3'h5 && errSig != 3'h6)
    else $error("reserved signature produced");
  par_ignore_a: assert property (@(posedge clk) disable iff (rst)
    phyCtrl[5] && errIn.parity && !errIn.frame && !errIn.clock &&
    !errIn.contention && !tmoHit |-> newSig == 3'h0)
    else $error("parity flagged while ignored");
  rsp_block_a: assert property (@(posedge clk) disable iff (rst)
    phyCtrl[3] |-> !rspAllow)
    else $error("response sent while suppressed");
  guard_time_a: assert property (@(posedge clk) disable iff (rst)
    txStart && !linkDisable && phyCtrl[2:0] == 3'h0 |=> txWait == 16'd128)
    else $error("default guard time wrong");
  gap_time_a: assert property (@(posedge clk) disable iff (rst)
    txNextByte && !txStart && !linkDisable && phyCtrl[7]
    |=> txWait == 16'd24)
    else $error("inter byte gap wrong");
  disable_reset_a: assert property (@(posedge clk) disable iff (rst)
    linkDisable && !wrDis |=> phyCtrl == 8'h00 && errSig == 3'h0 &&
    !clkReq)
    else $error("disable did not reset link");
  rev_read_a: assert property (@(posedge clk) disable iff (rst)
    req.rd && req.addr == 4'h0 |=> rdData == {REVISION, 4'h0})
    else $error("revision read wrong");
  // Further checks on the time-out, steering, guard time, first byte and unused bits.
  tmo_off_a: assert property (@(posedge clk) disable iff (rst)
    tmoHit |-> !phyCtrl[4])
    else $error("time-out while detection off");
  tmo_sig_a: assert property (@(posedge clk) disable iff (rst)
    tmoHit && !errIn.clock && !(errIn.contention && contOk) &&
    !linkDisable |=> errSig == 3'h3)
    else $error("time-out signature not loaded");
  cont_off_a: assert property (@(posedge clk) disable iff (rst)
    disCtrl[3] |-> !contentionOn)
    else $error("contention detect not off");
  nack_block_a: assert property (@(posedge clk) disable iff (rst)
    sysResetHit && disCtrl[4] |-> !nackAllow)
    else $error("nack sent while suppressed");
  clk_req_a: assert property (@(posedge clk) disable iff (rst)
    clkReq != linkDisable)
    else $error("clock request wrong");
  acc_sel_a: assert property (@(posedge clk) disable iff (rst)
    accSel |-> req.addr >= 4'h4 && req.addr <= 4'hc)
    else $error("access select out of range");
  gt_off_a: assert property (@(posedge clk) disable iff (rst)
    txStart && !linkDisable && phyCtrl[2:0] == 3'h7 |=> txWait == 16'h0000)
    else $error("guard time not off");
  first_byte_a: assert property (@(posedge clk) disable iff (rst)
    txStart && !linkDisable && phyCtrl[7] && phyCtrl[2:0] == 3'h0
    |=> txWait == 16'h0080)
    else $error("first byte got the gap");
  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    !phyCtrl[6] && disCtrl[7:5] == 3'h0 && disCtrl[1:0] == 2'h0)
    else $error("unused bit set");
endmodule : dlpc_link_phy_regs

// >>> hdl/dlpc_pkg.sv
// Package with the register map, field layout and constants of the link PHY.
package dlpc_pkg;
  // Register offsets on the link register space.
  localparam logic [3:0] DLPC_OFS_REV = 4'h0;
  localparam logic [3:0] DLPC_OFS_ERR = 4'h1;
  localparam logic [3:0] DLPC_OFS_PHY = 4'h2;
  localparam logic [3:0] DLPC_OFS_DIS = 4'h3;
  localparam logic [3:0] DLPC_OFS_PHY_LAST = 4'h3;
  localparam logic [3:0] DLPC_OFS_ACC_LAST = 4'hc;
  // Field positions in the phy control register.
  localparam int DLPC_POS_GAP = 7;
  localparam int DLPC_POS_PAR = 5;
  localparam int DLPC_POS_TMO = 4;
  localparam int DLPC_POS_RSP = 3;
  // Field positions in the disable control register.
  localparam int DLPC_POS_NACK = 4;
  localparam int DLPC_POS_CONT = 3;
  localparam int DLPC_POS_DIS = 2;
  // Writable masks; other bits read as zero.
  localparam logic [7:0] DLPC_PHY_MASK = 8'hbf;
  localparam logic [7:0] DLPC_DIS_MASK = 8'h1c;
  // Reset values.
  localparam logic [7:0] DLPC_PHY_RST = 8'h00;
  localparam logic [7:0] DLPC_DIS_RST = 8'h00;
  localparam logic [2:0] DLPC_SIG_RST = 3'h0;
  // Error signature codes.
  localparam logic [2:0] DLPC_SIG_NONE = 3'h0;
  localparam logic [2:0] DLPC_SIG_PAR = 3'h1;
  localparam logic [2:0] DLPC_SIG_FRM = 3'h2;
  localparam logic [2:0] DLPC_SIG_TMO = 3'h3;
  localparam logic [2:0] DLPC_SIG_CLK = 3'h4;
  localparam logic [2:0] DLPC_SIG_CONT = 3'h7;
  // Guard time base and off code.
  localparam int DLPC_GT_MAX_CYC = 128;
  localparam logic [2:0] DLPC_GT_OFF = 3'h7;
  // Access layer time-out in link clock cycles.
  localparam int DLPC_TMO_CYC = 65536;
  // Inter-byte gap: two idle characters of this many bit times each.
  localparam int DLPC_IDLE_CHARS = 2;
  localparam int DLPC_CHAR_BITS = 12;

  // Raw error events from the framing logic, one cycle pulses.
  typedef struct packed {
    logic parity;
    logic frame;
    logic clock;
    logic contention;
  } dlpc_err_t;

  // Register access request.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } dlpc_req_t;
endpackage : dlpc_pkg

// >>> test/dlpc_acc_model.sv
// Behavioural model of the access layer that answers the link PHY.
`timescale 1ns/1ps
module dlpc_acc_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  output logic accBusy,
  output logic accDone
);
  // Cycles left until the answer; a slow answer outlasts the time-out.
  logic [5:0] cnt;
  assign accBusy = (cnt != 6'h0);
  assign accDone = (cnt == 6'h1);
  // Load a short or long latency on each request, then count down.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 6'h0;
    end else if (go) begin
      cnt <= slow ? 6'h28 : 6'h2;
    end else if (cnt != 6'h0) begin
      cnt <= cnt - 6'h1;
    end
  end
endmodule : dlpc_acc_model

// >>> test/dlpc_link_phy_regs_tb.sv
// Self-checking bench of the link PHY register block.
`timescale 1ns/1ps
module dlpc_link_phy_regs_tb;
  import dlpc_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic go = 0;
  logic slow = 0;
  logic txStart = 0;
  logic txNextByte = 0;
  logic sysHit = 1;
  logic accBusy, accDone, accSel, rspAllow, nackAllow;
  logic contentionOn, linkDisable, clkReq;
  logic [7:0] rdData;
  logic [15:0] txWait;
  dlpc_req_t req = '0;
  dlpc_err_t errIn = '0;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // Short time-out keeps the run brief; revision chosen arbitrarily.
  dlpc_link_phy_regs #(.REVISION(4'h5), .TMO_CYC(16)) dlpc_link_phy_regs_i (
    .clk(clk), .rst(rst), .req(req), .rdData(rdData), .accSel(accSel),
    .errIn(errIn), .accBusy(accBusy), .accDone(accDone),
    .sysResetHit(sysHit), .rspWanted(1'b1), .nackWanted(1'b1),
    .txStart(txStart), .txNextByte(txNextByte), .rspAllow(rspAllow),
    .nackAllow(nackAllow), .contentionOn(contentionOn),
    .txWait(txWait), .linkDisable(linkDisable), .clkReq(clkReq));
  dlpc_acc_model dlpc_acc_model_i (.clk(clk), .rst(rst), .go(go),
    .slow(slow), .accBusy(accBusy), .accDone(accDone));
  initial forever #12.5 clk = ~clk;
  // Hang guard: the whole sequence needs well under 2000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc > 4000) begin
      err_count++;
      finish_test();
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Requests leave an idle cycle between them so no signal moves twice.
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = '{rd: 1'b0, wr: 1'b1, addr: a, data: d};
    @(posedge clk);
    #1 req = '0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 req = '{rd: 1'b1, wr: 1'b0, addr: a, data: 8'h00};
    @(posedge clk);
    #1 req = '0;
    chk(rdData, e);
  endtask : rd
  task err1(input logic [3:0] v, input logic [7:0] e);
    @(posedge clk);
    #1 errIn = v;
    @(posedge clk);
    #1 errIn = '0;
    rd(4'h1, e);
    rd(4'h1, 8'h00);
  endtask : err1
  task txp(input logic nb, input logic [15:0] e);
    @(posedge clk);
    #1 txStart = ~nb;
    txNextByte = nb;
    @(posedge clk);
    #1 txStart = 0;
    txNextByte = 0;
    chk(txWait, e);
  endtask : txp
  task t_regs;
    rd(4'h0, 8'h50);
    rd(4'h2, 8'h00);
    rd(4'h3, 8'h00);
    chk(clkReq, 1'b1);
    chk(nackAllow, 1'b1);
    wr(4'h2, 8'hff); // set every writable phy control bit
    rd(4'h2, 8'hbf);
    chk(rspAllow, 1'b0);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h50);
    wr(4'h2, 8'h00);
    chk(rspAllow, 1'b1);
    @(posedge clk);
    #1 req.addr = 4'hc;
    #1 chk(accSel, 1'b1);
    req.addr = 4'h3;
    #1 chk(accSel, 1'b0);
    $display("test regs done");
  endtask : t_regs
  task t_err;
    for (int i = 0; i < 4; i++) begin
      err1(4'h8 >> i, (i == 3) ? 8'h07 : 8'h01 << i);
    end
    wr(4'h2, 8'h20);
    err1(4'h8, 8'h00);
    wr(4'h3, 8'h08);
    chk(contentionOn, 1'b0);
    err1(4'h1, 8'h00);
    wr(4'h3, 8'h00);
    $display("test errors done");
  endtask : t_err
  // One slow access times out; with detection off it stays silent.
  task t_tmo(input logic [7:0] phy, input logic s, input logic [7:0] e);
    wr(4'h2, phy);
    slow = s;
    @(posedge clk);
    #1 go = 1;
    @(posedge clk);
    #1 go = 0;
    repeat (50) @(posedge clk);
    #1 rd(4'h1, e);
    $display("test timeout done");
  endtask : t_tmo
  task t_tx;
    for (int s = 0; s < 8; s++) begin
      wr(4'h2, s[7:0]);
      txp(1'b0, (s == 7) ? 16'h0 : 16'h80 >> s);
    end
    txp(1'b1, 16'h0);
    wr(4'h2, 8'h80);
    txp(1'b0, 16'h80);
    txp(1'b1, 16'h18);
    $display("test guard done");
  endtask : t_tx
  task t_dis;
    wr(4'h3, 8'h10);
    chk(nackAllow, 1'b0);
    sysHit = 0;
    #1 chk(nackAllow, 1'b1);
    sysHit = 1;
    wr(4'h3, 8'h04);
    chk({linkDisable, clkReq}, 2'b10);
    rd(4'h2, 8'h00);
    $display("test disable done");
  endtask : t_dis
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    t_regs();
    t_err();
    t_tmo(8'h00, 1'b1, 8'h03);
    t_tmo(8'h10, 1'b1, 8'h00);
    t_tmo(8'h00, 1'b0, 8'h00);
    t_tx();
    t_dis();
    finish_test();
  end
endmodule : dlpc_link_phy_regs_tb
